/* File: src/hbd_params.svh */
// Timing, width and limit constants for the half-bridge input decoder
`ifndef HBD_PARAMS_SVH
`define HBD_PARAMS_SVH

// =====================================================================
// Clock
`define HBD_CLK_NS 5

// =====================================================================
// Full-duty monitoring pulse periods
`define HBD_FULL_20K_NS 50000
`define HBD_FULL_40K_NS 25000
`define HBD_FULL_20K_CYC (`HBD_FULL_20K_NS / `HBD_CLK_NS)
`define HBD_FULL_40K_CYC (`HBD_FULL_40K_NS / `HBD_CLK_NS)

// =====================================================================
// Minimum dead time, least time so rounded up
`define HBD_DEAD_NS 20
`define HBD_DEAD_CYC ((`HBD_DEAD_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS)
`define HBD_DEAD_CNT_W 8

// =====================================================================
// Current limit scaling
`define HBD_LIM_W 9
`define HBD_CUR_W 14
`define HBD_LIM_SPAN_MV 400
`define HBD_LIM_MAX_MA 8000
`define HBD_MA_PER_MV (`HBD_LIM_MAX_MA / `HBD_LIM_SPAN_MV)

// =====================================================================
// Reset values
`define HBD_RST_SEL 1'b0
`define HBD_RST_MODE 2'h0

`endif

/* File: src/hbd_pkg.sv */
// Types shared by the half-bridge input decoder modules
package hbd_pkg;

	typedef enum logic [1:0] {
		HBD_MODE_6X = 2'h0,
		HBD_MODE_3X = 2'h1,
		HBD_MODE_6X_CL = 2'h2,
		HBD_MODE_3X_CL = 2'h3
	} hbd_mode_type;

	typedef enum logic [2:0] {
		HBD_DRV_OFF = 3'h1,
		HBD_DRV_HIGH = 3'h2,
		HBD_DRV_LOW = 3'h4
	} hbd_drive_type;

endpackage : hbd_pkg

/* File: src/hbd_phase.sv */
// One half-bridge: level and enable decode with dead-time enforcement
`timescale 1ns/1ps
`include "hbd_params.svh"

module hbd_phase import hbd_pkg::*; #(
	parameter int DEAD_CYC = `HBD_DEAD_CYC,
	parameter int CW = `HBD_DEAD_CNT_W
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_enable,
	input wire logic i_level,
	input wire logic i_chop,
	output logic o_hs_on,
	output logic o_ls_on
);

	typedef struct packed {
		hbd_drive_type drv;
		logic last_hi;
		logic [CW-1:0] off_cnt;
	} hbd_phase_state_type;

	localparam logic [CW-1:0] CNT_MAX = '1;
	localparam logic [CW-1:0] DEAD = CW'(DEAD_CYC);

	hbd_phase_state_type state_r;
	hbd_phase_state_type state_nxt;
	hbd_drive_type want;

	if (DEAD_CYC < 1 || DEAD_CYC > (2 ** CW) - 2) begin : g_bad_dead
		$error("hbd_phase: DEAD_CYC out of range");
	end

	// =================================================================
	// Drive state
	always_comb begin
		state_nxt = state_r;
		if (!i_enable || i_chop) begin
			want = HBD_DRV_OFF;
		end else if (i_level) begin
			want = HBD_DRV_HIGH;
		end else begin
			want = HBD_DRV_LOW;
		end
		case (state_r.drv)
			HBD_DRV_OFF: begin
				if (state_r.off_cnt != CNT_MAX) begin
					state_nxt.off_cnt = state_r.off_cnt + 1'b1;
				end
				// Opposite switch waits out the dead time; a longer gap from outside is kept
				if (want == HBD_DRV_HIGH && (state_r.last_hi || state_r.off_cnt >= DEAD)) begin
					state_nxt.drv = HBD_DRV_HIGH;
					state_nxt.last_hi = 1'b1;
				end else if (want == HBD_DRV_LOW &&
						(!state_r.last_hi || state_r.off_cnt >= DEAD)) begin
					state_nxt.drv = HBD_DRV_LOW;
					state_nxt.last_hi = 1'b0;
				end
			end
			HBD_DRV_HIGH: begin
				if (want != HBD_DRV_HIGH) begin
					state_nxt.drv = HBD_DRV_OFF;
					state_nxt.off_cnt = CW'(1);
				end
			end
			HBD_DRV_LOW: begin
				if (want != HBD_DRV_LOW) begin
					state_nxt.drv = HBD_DRV_OFF;
					state_nxt.off_cnt = CW'(1);
				end
			end
			default: begin
				state_nxt.drv = HBD_DRV_OFF;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= '{drv: HBD_DRV_OFF, last_hi: 1'b0, off_cnt: '1};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_hs_on = state_r.drv[1];
	assign o_ls_on = state_r.drv[2];

	// =================================================================
	// Checks
	logic [CW-1:0] gap_r;
	logic hs_last_r;

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gap_r <= '1;
			hs_last_r <= 1'b0;
		end else if (o_hs_on || o_ls_on) begin
			gap_r <= '0;
			hs_last_r <= o_hs_on;
		end else if (gap_r != CNT_MAX) begin
			gap_r <= gap_r + 1'b1;
		end
	end

	chk_off_when_disabled: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		!i_enable |=> !o_hs_on && !o_ls_on)
		else $error("phase driven while disabled");

	chk_low_follows: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_enable && !i_level && !i_chop) [*8] |-> o_ls_on && !o_hs_on)
		else $error("phase not low after steady low request");

	chk_no_overlap: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		!(o_hs_on && o_ls_on))
		else $error("both switches on");

	chk_dead_gap: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		($rose(o_ls_on) && hs_last_r) || ($rose(o_hs_on) && !hs_last_r)
		|-> $past(gap_r) >= DEAD - 1'b1)
		else $error("dead time shorter than minimum");

endmodule : hbd_phase

/* File: src/hbd_top.sv */
// Three half-bridge input decoder with cycle-by-cycle current limit
`timescale 1ns/1ps
`include "hbd_params.svh"

module hbd_top import hbd_pkg::*; #(
	parameter int FULL_20K_CYC = `HBD_FULL_20K_CYC,
	parameter int FULL_40K_CYC = `HBD_FULL_40K_CYC,
	parameter int DEAD_CYC = `HBD_DEAD_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_phase_one_level,
	input wire logic i_phase_two_level,
	input wire logic i_phase_three_level,
	input wire logic i_phase_one_enable,
	input wire logic i_phase_two_enable,
	input wire logic i_phase_three_enable,
	input wire logic [1:0] i_pwm_mode,
	input wire logic i_full_duty_sel,
	input wire logic [`HBD_LIM_W-1:0] i_current_limit_level,
	input wire logic [`HBD_CUR_W-1:0] i_phase_one_current,
	input wire logic [`HBD_CUR_W-1:0] i_phase_two_current,
	input wire logic [`HBD_CUR_W-1:0] i_phase_three_current,
	input wire logic [2:0] i_current_into_pin,
	output logic [2:0] o_phase_hs_on,
	output logic [2:0] o_phase_ls_on,
	output logic [`HBD_CUR_W-1:0] o_phase_one_sense_output,
	output logic [`HBD_CUR_W-1:0] o_phase_two_sense_output,
	output logic [`HBD_CUR_W-1:0] o_phase_three_sense_output,
	output logic [2:0] o_phase_sense_valid,
	output logic [2:0] o_limit_trip
);

	localparam int LW = `HBD_LIM_W;
	localparam int CW = `HBD_CUR_W;
	localparam int PCW = $clog2(FULL_20K_CYC + 1);
	localparam logic [LW-1:0] LIM_SPAN = LW'(`HBD_LIM_SPAN_MV);
	localparam logic [CW-1:0] LIM_MAX = CW'(`HBD_LIM_MAX_MA);
	localparam logic [CW-1:0] MA_PER_MV = CW'(`HBD_MA_PER_MV);
	localparam logic [PCW-1:0] P20_LAST = PCW'(FULL_20K_CYC - 1);
	localparam logic [PCW-1:0] P40_LAST = PCW'(FULL_40K_CYC - 1);

	if (FULL_40K_CYC < 2 || FULL_20K_CYC < FULL_40K_CYC) begin : g_bad_period
		$error("hbd_top: full-duty periods out of range");
	end

	typedef struct packed {
		logic [2:0] lvl_s1;
		logic [2:0] lvl_s2;
		logic [2:0] lvl_d;
		logic [2:0] en_s1;
		logic [2:0] en_s2;
		logic [1:0] mode_s1;
		logic [1:0] mode_s2;
		logic sel_s1;
		logic sel_s2;
		logic [LW-1:0] lim_s1;
		logic [LW-1:0] lim_s2;
		logic [LW-1:0] lim_d;
		logic [CW-1:0] thr;
		logic [PCW-1:0] pcnt;
		logic [2:0] chop;
		logic [2:0] valid;
		logic [2:0][CW-1:0] sense;
	} hbd_top_state_type;

	hbd_top_state_type state_r;
	hbd_top_state_type state_nxt;
	logic [2:0][CW-1:0] cur;
	logic [2:0] rise;
	logic [2:0] trip;
	logic [2:0] hs_on;
	logic [2:0] ls_on;
	logic [PCW-1:0] period_last;
	logic pstart;
	logic cl_mode;

	assign cur[0] = i_phase_one_current;
	assign cur[1] = i_phase_two_current;
	assign cur[2] = i_phase_three_current;

	// =================================================================
	// Input synchronisers, threshold, period and limit logic
	always_comb begin
		state_nxt = state_r;
		state_nxt.lvl_s1 = {i_phase_three_level, i_phase_two_level, i_phase_one_level};
		state_nxt.en_s1 = {i_phase_three_enable, i_phase_two_enable, i_phase_one_enable};
		state_nxt.mode_s1 = i_pwm_mode;
		state_nxt.sel_s1 = i_full_duty_sel;
		state_nxt.lim_s1 = i_current_limit_level;
		state_nxt.lvl_s2 = state_r.lvl_s1;
		state_nxt.en_s2 = state_r.en_s1;
		state_nxt.mode_s2 = state_r.mode_s1;
		state_nxt.sel_s2 = state_r.sel_s1;
		state_nxt.lim_s2 = state_r.lim_s1;
		state_nxt.lvl_d = state_r.lvl_s2;
		state_nxt.lim_d = state_r.lim_s2;

		// Level is millivolts below the midpoint; zero means limiting off
		// Level word taken only once two synced samples agree, so a skewed crossing is ignored
		if (state_r.lim_s2 != state_r.lim_d) begin
			state_nxt.thr = state_r.thr;
		end else if (state_r.lim_s2 == '0) begin
			state_nxt.thr = '0;
		end else if (state_r.lim_s2 >= LIM_SPAN) begin
			state_nxt.thr = LIM_MAX;
		end else begin
			state_nxt.thr = CW'(state_r.lim_s2) * MA_PER_MV;
		end

		cl_mode = (state_r.mode_s2 == HBD_MODE_6X_CL) ||
			(state_r.mode_s2 == HBD_MODE_3X_CL);

		// External PWM edges start a period; without them the internal pulse does
		rise = state_r.lvl_s2 & ~state_r.lvl_d & state_r.en_s2;
		period_last = state_r.sel_s2 ? P40_LAST : P20_LAST;
		pstart = (|rise) || (state_r.pcnt >= period_last);
		if (pstart) begin
			state_nxt.pcnt = '0;
		end else begin
			state_nxt.pcnt = state_r.pcnt + 1'b1;
		end

		for (int i = 0; i < 3; i++) begin
			// Current is seen only on the low-side path
			state_nxt.valid[i] = ls_on[i] && i_current_into_pin[i];
			state_nxt.sense[i] = state_nxt.valid[i] ? cur[i] : '0;
			trip[i] = cl_mode && (state_r.thr != '0) && state_nxt.valid[i] &&
				(cur[i] > state_r.thr);
		end
		// A trip in the same cycle as a period start wins over the release
		state_nxt.chop = (state_r.chop & {3{~pstart}}) | trip;
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= '0;
			state_r.mode_s1 <= `HBD_RST_MODE;
			state_r.mode_s2 <= `HBD_RST_MODE;
			state_r.sel_s1 <= `HBD_RST_SEL;
			state_r.sel_s2 <= `HBD_RST_SEL;
		end else begin
			state_r <= state_nxt;
		end
	end

	// =================================================================
	// Half bridges
	for (genvar g = 0; g < 3; g++) begin : g_phase
		hbd_phase #(
			.DEAD_CYC(DEAD_CYC),
			.CW(`HBD_DEAD_CNT_W)
		) u_phase (
			.i_ref_clk(i_ref_clk),
			.i_nrst(i_nrst),
			.i_enable(state_r.en_s2[g]),
			.i_level(state_r.lvl_s2[g]),
			.i_chop(state_r.chop[g]),
			.o_hs_on(hs_on[g]),
			.o_ls_on(ls_on[g])
		);
	end

	assign o_phase_hs_on = hs_on;
	assign o_phase_ls_on = ls_on;
	assign o_phase_one_sense_output = state_r.sense[0];
	assign o_phase_two_sense_output = state_r.sense[1];
	assign o_phase_three_sense_output = state_r.sense[2];
	assign o_phase_sense_valid = state_r.valid;
	assign o_limit_trip = state_r.chop;

	// =================================================================
	// Checks
	chk_limit_off_mid: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(state_r.lim_s2 == '0) && (state_r.lim_d == '0) |=> (state_r.thr == '0))
		else $error("threshold not off at midpoint");

	chk_limit_max_level: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(state_r.lim_s2 == LIM_SPAN) && (state_r.lim_d == LIM_SPAN) |=> (state_r.thr == LIM_MAX))
		else $error("threshold not at maximum");

	chk_trip_needs_mode: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(|(o_limit_trip & ~$past(o_limit_trip))) |-> $past(cl_mode))
		else $error("limit tripped outside limit modes");

	chk_full_duty_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(state_r.pcnt == P40_LAST) && state_r.sel_s2 && !(|rise) |=> state_r.pcnt == '0)
		else $error("40 kHz pulse period wrong");

	chk_slow_rate_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(state_r.pcnt == P40_LAST) && !state_r.sel_s2 && !(|rise) |=> state_r.pcnt != '0)
		else $error("20 kHz pulse ended early");

	chk_sense_lowside: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(|o_phase_sense_valid) |-> (($past(o_phase_ls_on) & o_phase_sense_valid)
			== o_phase_sense_valid))
		else $error("sense valid without low-side conduction");

	chk_no_hs_trip: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(|(o_limit_trip & ~$past(o_limit_trip) & $past(o_phase_hs_on))) == 1'b0)
		else $error("trip from high-side current");

	chk_chop_release: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		pstart && !(|trip) |=> (o_limit_trip == 3'h0))
		else $error("limit not released at period start");

	cov_trip: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
		|(o_limit_trip & ~$past(o_limit_trip)));

	cov_internal_pulse: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
		pstart && !(|rise) && cl_mode);

	cov_sense_valid: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
		|o_phase_sense_valid);

endmodule : hbd_top

/* File: test/hbd_ctrl_model.sv */
// Controller model driving level and enable pins for a bridge and a solenoid
`timescale 1ns/1ps

module hbd_ctrl_model (
	input wire logic i_ref_clk,
	input wire logic [2:0] i_cmd,
	output logic [2:0] o_level,
	output logic [2:0] o_enable
);
	initial begin
		o_level = 3'h0;
		o_enable = 3'h0;
	end

	// =====================================================================
	// Command decode
	// Phases one and two form a bridge; phase three holds a solenoid to the motor supply
	always @(posedge i_ref_clk) begin
		case (i_cmd)
			3'h0: {o_enable[1:0], o_level[1:0]} <= 4'h0;
			3'h1: {o_enable[1:0], o_level[1:0]} <= 4'hd;
			3'h2: {o_enable[1:0], o_level[1:0]} <= 4'he;
			3'h3: {o_enable[1:0], o_level[1:0]} <= 4'hc;
			3'h4: {o_enable[1:0], o_level[1:0]} <= 4'hf;
			3'h5: {o_enable[2], o_level[2]} <= 2'h2;
			3'h6: {o_enable[2], o_level[2]} <= 2'h3;
			default: {o_enable[2], o_level[2]} <= 2'h0;
		endcase
	end
endmodule : hbd_ctrl_model

/* File: test/hbd_top_test.sv */
// Self-checking bench for the three half-bridge input decoder
`timescale 1ns/1ps
`include "hbd_params.svh"

module hbd_top_test import hbd_pkg::*;;
	localparam int P20 = 40;
	localparam int P40 = 20;
	localparam int DEAD = 4;
	// Rows: command, expected high sides, expected low sides
	localparam logic [8:0] ROWS [8] = '{9'h04a, 9'h091, 9'h0c3, 9'h118, 9'h000, 9'h144,
		9'h1a0, 9'h1c0};
	logic clk;
	logic nrst;
	logic sel;
	logic [2:0] cmd, lvl, en, into, hs, ls, sv, trip;
	logic [1:0] mode;
	logic [`HBD_LIM_W-1:0] lim;
	logic [`HBD_CUR_W-1:0] cur1, cur2, cur3, s1, s2, s3;
	int fails = 0;
	int n_compared = 0;
	int tf, tr, n;

	hbd_ctrl_model i_hbd_ctrl_model (.i_ref_clk(clk), .i_cmd(cmd), .o_level(lvl), .o_enable(en));

	hbd_top #(.FULL_20K_CYC(P20), .FULL_40K_CYC(P40), .DEAD_CYC(DEAD)) i_hbd_top (
		.i_ref_clk(clk), .i_nrst(nrst),
		.i_phase_one_level(lvl[0]), .i_phase_two_level(lvl[1]), .i_phase_three_level(lvl[2]),
		.i_phase_one_enable(en[0]), .i_phase_two_enable(en[1]), .i_phase_three_enable(en[2]),
		.i_pwm_mode(mode), .i_full_duty_sel(sel), .i_current_limit_level(lim),
		.i_phase_one_current(cur1), .i_phase_two_current(cur2), .i_phase_three_current(cur3),
		.i_current_into_pin(into), .o_phase_hs_on(hs), .o_phase_ls_on(ls),
		.o_phase_one_sense_output(s1), .o_phase_two_sense_output(s2),
		.o_phase_three_sense_output(s3), .o_phase_sense_valid(sv), .o_limit_trip(trip)
	);

	// =====================================================================
	// Tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		if (fails == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	task automatic go(input logic [2:0] c, input int w);
		@(posedge clk);
		cmd <= c;
		repeat (w) @(posedge clk);
		#1;
	endtask : go

	task automatic set_lim(input logic [1:0] m, input logic [8:0] l, input logic [13:0] c,
		input int w);
		@(posedge clk);
		mode <= m;
		lim <= l;
		cur1 <= c;
		repeat (w) @(posedge clk);
		#1;
	endtask : set_lim

	// Edge counts from the command edge to phase one high side off and low side on
	task automatic watch(input logic [2:0] c);
		tf = 0;
		tr = 0;
		@(posedge clk);
		cmd <= c;
		for (int k = 1; k <= 40; k++) begin
			@(posedge clk);
			#1;
			if (tf == 0 && hs[0] === 1'b0) tf = k;
			if (tr == 0 && ls[0] === 1'b1) tr = k;
		end
	endtask : watch

	task automatic wait_lvl(input logic v, inout int cnt);
		for (int t = 0; t < 200 && trip[0] !== v; t++) begin
			@(posedge clk);
			#1;
			cnt++;
		end
	endtask : wait_lvl

	// Cycles between two successive trip releases under steady overcurrent
	task automatic per();
		wait_lvl(1'b1, n);
		wait_lvl(1'b0, n);
		n = 0;
		wait_lvl(1'b1, n);
		wait_lvl(1'b0, n);
	endtask : per

	// =====================================================================
	// Clock, watchdog and sequence
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (6000) @(posedge clk);
		fails++;
		finish_test();
	end

	initial begin
		nrst = 1'b0;
		cmd = 3'h0;
		sel = 1'b0;
		mode = HBD_MODE_6X;
		lim = 9'h190;
		into = 3'h7;
		cur1 = 14'h2000;
		cur2 = 14'h2000;
		cur3 = 14'h2000;
		@(posedge clk);
		#1;
		check("reset drive", {hs, ls, trip}, 9'h000);
		@(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			go(ROWS[i][8:6], 12);
			check("hs", hs, ROWS[i][5:3]);
			check("ls", ls, ROWS[i][2:0]);
			check("valid", sv, ROWS[i][2:0]);
			check("sense", s1, ROWS[i][0] ? 14'h2000 : 14'h0);
			check("sense2", s2, ROWS[i][1] ? 14'h2000 : 14'h0);
			check("sense3", s3, ROWS[i][2] ? 14'h2000 : 14'h0);
			check("trip off", trip, 3'h0);
		end
		go(3'h4, 12);
		watch(3'h3);
		check("dead gap", tr - tf, DEAD);
		go(3'h4, 12);
		go(3'h0, 12);
		watch(3'h3);
		check("long off", tr, 4);
		set_lim(HBD_MODE_6X_CL, 9'h064, 14'h7d0, 60);
		check("at thr", trip[0], 1'b0);
		set_lim(HBD_MODE_6X_CL, 9'h064, 14'h7d1, 0);
		wait_lvl(1'b1, n);
		check("over thr", trip[0], 1'b1);
		@(posedge clk);
		#1;
		check("off", ls[0], 1'b0);
		per();
		check("p20", n, P20);
		@(posedge clk);
		sel <= 1'b1;
		per();
		per();
		check("p40", n, P40);
		set_lim(HBD_MODE_6X_CL, 9'h190, 14'h1f40, 60);
		check("max ok", trip[0], 1'b0);
		set_lim(HBD_MODE_6X_CL, 9'h190, 14'h1f41, 0);
		wait_lvl(1'b1, n);
		check("max trip", trip[0], 1'b1);
		set_lim(HBD_MODE_6X_CL, 9'h000, 14'h3fff, 60);
		check("lim off", trip[0], 1'b0);
		set_lim(HBD_MODE_3X_CL, 9'h064, 14'h7d1, 0);
		wait_lvl(1'b1, n);
		check("3x trip", trip[0], 1'b1);
		set_lim(HBD_MODE_3X, 9'h064, 14'h3fff, 60);
		check("3x none", trip[0], 1'b0);
		set_lim(HBD_MODE_6X_CL, 9'h064, 14'h3fff, 0);
		@(posedge clk);
		into <= 3'h0;
		go(3'h4, 60);
		check("src trip", trip[0], 1'b0);
		check("src valid", {sv[0], s1}, 15'h0000);
		check("src hs", hs, 3'h3);
		// Reset in mid-run, then the drive must come back
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		#1;
		check("mid reset", {hs, ls, trip, sv}, 12'h000);
		@(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		check("first edge", {hs, ls}, 6'h00);
		go(3'h4, 12);
		check("reset rerun", hs, 3'h3);
		finish_test();
	end
endmodule : hbd_top_test
